//--- bfc_pkg.sv
// Shared constants for the FIFO pair configuration unit.
// Assumes one APB slave at pclk; the port pins are synchronised before use.
// Function
// [R1] FIFO one rewinds its read pointer after four edges of both port clocks.
// [R2] FIFO two rewinds its read pointer after four edges of both port clocks.
// [R3] The controller holds the rewind mode select high during any rewind.
// [R4] Shared pin rewinds when mode select is high, partially clears when low.
// [R5] Byte order pin high at master reset release selects big-endian.
// [R6] Big-endian: first Port B beat lands in the most significant lane.
// [R7] Byte order pin low at master reset release selects little-endian.
// [R8] Little-endian: first Port B beat lands in the least significant lane.
// [R9] A full 36-bit Port B ignores the byte order.
// [R10] First port clock edge after release samples the timing pin; high is standard.
// [R11] A low sample at that edge selects fall-through timing.
// [R12] Standard timing drives empty and full, presenting words only on reads.
// [R13] Fall-through drives valid and room, presenting the first word unasked.
// [R14] The controller keeps the byte order pin static after master reset.
// [R15] Four offsets drive the almost-empty and almost-full flags of both ports.
// [R16] Preset offsets load from the flag selects at master reset release; FIFO two loads them only on a joint release, else clears them to 0.
// [R17] Both resets rising with selects 0 and 1 low choose parallel loading.
// [R18] The controller keeps selects 0 and 1 low after choosing parallel loading.
// [R19] First four Port A writes load full one, empty one, full two, empty two.
// [R20] Non-interspersed parity takes the offset from contiguous bits from bit 0.
// [R21] Interspersed parity skips Port A bit 8 when loading offsets.
// [R22] The highest Port A bit used is the offset's most significant bit.
// [R23] The controller programs offsets only within the legal range for depth.
// [R24] Flag select codes decode into five presets, serial or parallel loading.
// [R25] Port B room rises only after all four parallel offsets are loaded.
// [R26] A rewind changes only the read pointer, nothing else.
package bfc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] BFC_ADDR_CONFIG = 8'h00;
  localparam logic [7:0] BFC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] BFC_ADDR_OFS_ONE = 8'h08;
  localparam logic [7:0] BFC_ADDR_OFS_TWO = 8'h0C;
  localparam int BFC_OFS_FULL_POS = 16;
  localparam int BFC_ST_BIG_POS = 0;
  localparam int BFC_ST_FWFT1_POS = 1;
  localparam int BFC_ST_FWFT2_POS = 2;
  localparam int BFC_ST_IP_POS = 3;
  localparam int BFC_ST_DONE_POS = 4;
  localparam int BFC_ST_SERIAL_POS = 5;
  localparam logic [1:0] BFC_SIZE_LONG = 2'h0;
  localparam logic [1:0] BFC_SIZE_WORD = 2'h1;
  localparam logic [1:0] BFC_SIZE_BYTE = 2'h2;
  localparam logic [1:0] BFC_SIZE_RST = 2'h0;
  // ----------------------------------------
  // Flag select codes {bit2, bit1, bit0} and presets
  // ----------------------------------------
  localparam logic [2:0] BFC_FS_64 = 3'h7;
  localparam logic [2:0] BFC_FS_16 = 3'h6;
  localparam logic [2:0] BFC_FS_8 = 3'h5;
  localparam logic [2:0] BFC_FS_256 = 3'h3;
  localparam logic [2:0] BFC_FS_1024 = 3'h1;
  localparam logic [2:0] BFC_FS_SERIAL = 3'h2;
  localparam int BFC_PRESET_64 = 64;
  localparam int BFC_PRESET_16 = 16;
  localparam int BFC_PRESET_8 = 8;
  localparam int BFC_PRESET_256 = 256;
  localparam int BFC_PRESET_1024 = 1024;
  localparam int BFC_HOLD_EDGES = 4;
  localparam int BFC_SKIP_BIT = 8;
  typedef enum logic [3:0] {
    BFC_CLEAR = 4'h1,
    BFC_PLOAD = 4'h2,
    BFC_SERIAL = 4'h4,
    BFC_RUN = 4'h8
  } bfc_prog_t;
endpackage

//--- bfc_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes pins change slowly compared with pclk.
`timescale 1ns/1ps
module bfc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  input wire logic [W-1:0] pin_in,
  // Filtered levels and rising edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] r;
  } bfc_sync_t;
  bfc_sync_t st_r;
  bfc_sync_t st_nxt;
  // A level only counts once the second and third stages agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (~(st_r.s2 ^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.q);
    st_nxt.r = st_nxt.q & ~st_r.q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= {RST, RST, RST, RST, {W{1'b0}}};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign level = st_r.q;
  assign rise = st_r.r;
endmodule

//--- bfc_hold_count.sv
// Counts edges of both port clocks while a pin is held asserted.
// Assumes the tick inputs are one-cycle pulses on pclk.
`timescale 1ns/1ps
module bfc_hold_count #(
  parameter int NEED = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Hold level and port clock edges
  input wire logic hold,
  input wire logic tick_a,
  input wire logic tick_b,
  // One pulse per hold once both counts are reached
  output logic done
);
  localparam int CW = $clog2(NEED + 1);
  localparam logic [CW-1:0] FULL = CW'(NEED);
  typedef struct packed {
    logic [CW-1:0] ca;
    logic [CW-1:0] cb;
    logic fired;
    logic done;
  } bfc_hold_t;
  bfc_hold_t st_r;
  bfc_hold_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!hold) begin
      st_nxt.ca = '0;
      st_nxt.cb = '0;
      st_nxt.fired = 1'b0;
    end else begin
      if (tick_a && st_r.ca != FULL) begin
        st_nxt.ca = st_r.ca + CW'(1);
      end
      if (tick_b && st_r.cb != FULL) begin
        st_nxt.cb = st_r.cb + CW'(1);
      end
      // A long hold fires once; the pin must be released to fire again.
      st_nxt.done = !st_r.fired && st_nxt.ca == FULL && st_nxt.cb == FULL; // R1 R2
      st_nxt.fired = st_r.fired | st_nxt.done;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign done = st_r.done;
  a_hold_edges: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> (st_r.ca == FULL && st_r.cb == FULL && $past(hold))) // R1 R2
    else $error("Hold done without four edges of each clock.");
endmodule

//--- bfc_config_unit.sv
// Configuration, rewind and offset logic for a bidirectional FIFO pair.
// Assumes a datapath on pclk that owns memory, pointers and fill levels.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module bfc_config_unit #(
  parameter int ADDR_W = 11,
  parameter int AW_DATA = 36
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Asynchronous control pins
  input wire logic port_a_clock,
  input wire logic port_b_clock,
  input wire logic rewind_fifo_one_n,
  input wire logic rewind_fifo_two_n,
  input wire logic rewind_mode_select,
  input wire logic full_clear_fifo_one_n,
  input wire logic full_clear_fifo_two_n,
  input wire logic byte_order_timing_select,
  input wire logic flag_select_0_serial_in,
  input wire logic flag_select_1_serial_load_n,
  input wire logic flag_select_2,
  // Port A write pins
  input wire logic port_a_write,
  input wire logic [AW_DATA-1:0] port_a_data,
  // Datapath status
  input wire logic [ADDR_W:0] fifo_one_level,
  input wire logic [ADDR_W:0] fifo_two_level,
  input wire logic fifo_one_read,
  input wire logic fifo_two_read,
  input wire logic [1:0] port_b_beat,
  // Datapath control
  output logic [AW_DATA-1:0] port_a_word,
  output logic fifo_one_store,
  output logic fifo_one_rewind,
  output logic fifo_two_rewind,
  output logic fifo_one_partial_clear,
  output logic fifo_two_partial_clear,
  output logic fifo_one_present,
  output logic fifo_two_present,
  output logic [1:0] port_b_lane,
  output logic fall_through_mode_one,
  output logic fall_through_mode_two,
  // Port flags
  output logic port_a_full_n,
  output logic port_a_input_room,
  output logic port_b_full_n,
  output logic port_b_input_room,
  output logic port_a_empty_n,
  output logic port_a_output_valid,
  output logic port_b_empty_n,
  output logic port_b_output_valid,
  output logic port_a_almost_empty_n,
  output logic port_b_almost_empty_n,
  output logic port_a_almost_full_n,
  output logic port_b_almost_full_n
);
  import bfc_pkg::*;

  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  localparam int SW = AW_DATA + 12;
  localparam logic [SW-1:0] SYNC_RST = SW'(12'h00C);
  localparam logic [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
  localparam int PADW = 16 - ADDR_W;

  typedef struct packed {
    bfc_prog_t prog;
    logic big;
    logic ip;
    logic fwft1;
    logic fwft2;
    logic wait1;
    logic wait2;
    logic [1:0] idx;
    logic [ADDR_W-1:0] x1;
    logic [ADDR_W-1:0] y1;
    logic [ADDR_W-1:0] x2;
    logic [ADDR_W-1:0] y2;
    logic ov1;
    logic ov2;
    logic [1:0] bsize;
    logic [31:0] rdata;
    logic slverr;
  } bfc_cfg_t;

  // The highest Port A bit used always ends up as the offset's top bit.
  function automatic logic [ADDR_W-1:0] bfc_extract(input logic [AW_DATA-1:0] d,
                                                   input logic ip);
    if (ip) begin
      return {d[ADDR_W:BFC_SKIP_BIT+1], d[BFC_SKIP_BIT-1:0]}; // R21 R22
    end
    return d[ADDR_W-1:0]; // R20 R22
  endfunction

  function automatic logic bfc_preset_ok(input logic [2:0] fs);
    return fs == BFC_FS_64 || fs == BFC_FS_16 || fs == BFC_FS_8 ||
           fs == BFC_FS_256 || fs == BFC_FS_1024;
  endfunction

  function automatic logic [ADDR_W-1:0] bfc_preset(input logic [2:0] fs);
    case (fs)
      BFC_FS_64: return ADDR_W'(BFC_PRESET_64); // R24
      BFC_FS_16: return ADDR_W'(BFC_PRESET_16);
      BFC_FS_8: return ADDR_W'(BFC_PRESET_8);
      BFC_FS_256: return ADDR_W'(BFC_PRESET_256);
      BFC_FS_1024: return ADDR_W'(BFC_PRESET_1024);
      default: return '0;
    endcase
  endfunction

  function automatic logic [1:0] bfc_lane(input logic [1:0] size, input logic [1:0] beat,
                                          input logic big);
    case (size)
      BFC_SIZE_WORD: return big ? {1'b0, ~beat[0]} : {1'b0, beat[0]}; // R6 R8
      BFC_SIZE_BYTE: return big ? ~beat : beat; // R6 R8
      default: return 2'h0; // R9
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisation and hold counters
  // ----------------------------------------
  logic [SW-1:0] sync_level;
  logic [SW-1:0] sync_rise;
  bfc_pin_sync #(.W(SW), .RST(SYNC_RST)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({port_a_data, port_a_write, flag_select_2, flag_select_1_serial_load_n,
             flag_select_0_serial_in, byte_order_timing_select, full_clear_fifo_two_n,
             full_clear_fifo_one_n, rewind_mode_select, rewind_fifo_two_n,
             rewind_fifo_one_n, port_b_clock, port_a_clock}),
    .level(sync_level),
    .rise(sync_rise)
  );

  logic tick_a;
  logic tick_b;
  logic mode_q;
  logic full_clear_fifo_one_n_q;
  logic full_clear_fifo_two_n_q;
  logic full_clear_fifo_one_n_rise;
  logic full_clear_fifo_two_n_rise;
  logic bo_q;
  logic [2:0] fs_q;
  logic wr_q;
  logic hold1_done;
  logic hold2_done;
  assign tick_a = sync_rise[0];
  assign tick_b = sync_rise[1];
  assign mode_q = sync_level[4];
  assign full_clear_fifo_one_n_q = sync_level[5];
  assign full_clear_fifo_two_n_q = sync_level[6];
  assign full_clear_fifo_one_n_rise = sync_rise[5];
  assign full_clear_fifo_two_n_rise = sync_rise[6];
  assign bo_q = sync_level[7];
  assign fs_q = sync_level[10:8];
  assign wr_q = sync_level[11];
  assign port_a_word = sync_level[SW-1:12];

  bfc_hold_count #(.NEED(BFC_HOLD_EDGES)) u_hold_one (
    .pclk(pclk),
    .presetn(presetn),
    .hold(!sync_level[2]),
    .tick_a(tick_a),
    .tick_b(tick_b),
    .done(hold1_done)
  );
  bfc_hold_count #(.NEED(BFC_HOLD_EDGES)) u_hold_two (
    .pclk(pclk),
    .presetn(presetn),
    .hold(!sync_level[3]),
    .tick_a(tick_a),
    .tick_b(tick_b),
    .done(hold2_done)
  );

  // The meaning of the shared pin is fixed by mode select when the hold completes.
  assign fifo_one_rewind = hold1_done & mode_q; // R1 R4 R26
  assign fifo_two_rewind = hold2_done & mode_q; // R2 R4 R26
  assign fifo_one_partial_clear = hold1_done & !mode_q; // R4
  assign fifo_two_partial_clear = hold2_done & !mode_q; // R4

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  bfc_cfg_t st_r;
  bfc_cfg_t st_nxt;
  logic [ADDR_W-1:0] pload_word;
  logic apb_setup;
  logic apb_write;
  assign pload_word = bfc_extract(port_a_word, st_r.ip);
  assign apb_setup = psel & !penable;
  assign apb_write = psel & penable & pwrite;

  // Fall-through fetches without a read; standard only answers a read.
  assign fifo_one_present = st_r.fwft1 ?
    (full_clear_fifo_one_n_q && fifo_one_level != '0 && (!st_r.ov1 || fifo_one_read)) : // R13
    (fifo_one_read && fifo_one_level != '0); // R12
  assign fifo_two_present = st_r.fwft2 ?
    (full_clear_fifo_two_n_q && fifo_two_level != '0 && (!st_r.ov2 || fifo_two_read)) : // R13
    (fifo_two_read && fifo_two_level != '0); // R12

  always_comb begin
    st_nxt = st_r;
    if (full_clear_fifo_one_n_rise) begin
      st_nxt.big = bo_q; // R5 R7
      st_nxt.ip = !fs_q[2]; // R17
      st_nxt.wait1 = 1'b1;
      if (bfc_preset_ok(fs_q)) begin
        st_nxt.x1 = bfc_preset(fs_q); // R16
        st_nxt.y1 = bfc_preset(fs_q); // R16
      end
      if (full_clear_fifo_two_n_rise && fs_q == BFC_FS_SERIAL) begin
        st_nxt.prog = BFC_SERIAL;
      end else if (full_clear_fifo_two_n_rise && fs_q[1:0] == 2'h0) begin
        st_nxt.prog = BFC_PLOAD; // R17
        st_nxt.idx = 2'h0;
      end else begin
        st_nxt.prog = BFC_RUN;
      end
    end else if (!full_clear_fifo_one_n_q) begin
      st_nxt.prog = BFC_CLEAR;
      st_nxt.wait1 = 1'b0;
    end else if (st_r.wait1 && tick_a) begin
      st_nxt.fwft1 = !bo_q; // R10 R11
      st_nxt.wait1 = 1'b0;
    end
    if (full_clear_fifo_two_n_rise) begin
      st_nxt.wait2 = 1'b1;
      // A lone release clears the offsets; only a joint release loads presets.
      st_nxt.x2 = (full_clear_fifo_one_n_rise && bfc_preset_ok(fs_q)) ? bfc_preset(fs_q) : '0; // R16
      st_nxt.y2 = (full_clear_fifo_one_n_rise && bfc_preset_ok(fs_q)) ? bfc_preset(fs_q) : '0; // R16
    end else if (!full_clear_fifo_two_n_q) begin
      st_nxt.wait2 = 1'b0;
    end else if (st_r.wait2 && tick_b) begin
      st_nxt.fwft2 = !bo_q; // R10 R11
      st_nxt.wait2 = 1'b0;
    end
    if (st_r.prog == BFC_PLOAD && full_clear_fifo_one_n_q && tick_a && wr_q) begin
      case (st_r.idx)
        2'h0: st_nxt.y1 = pload_word; // R19
        2'h1: st_nxt.x1 = pload_word; // R19
        2'h2: st_nxt.y2 = pload_word; // R19
        default: st_nxt.x2 = pload_word; // R19
      endcase
      st_nxt.idx = st_r.idx + 2'h1;
      if (st_r.idx == 2'h3) begin
        st_nxt.prog = BFC_RUN; // R25
      end
    end
    // A rewind or clear makes the presented word stale.
    if (!st_r.fwft1 || !full_clear_fifo_one_n_q || hold1_done) begin
      st_nxt.ov1 = 1'b0;
    end else if (fifo_one_present) begin
      st_nxt.ov1 = 1'b1; // R13
    end else if (fifo_one_read) begin
      st_nxt.ov1 = 1'b0;
    end
    if (!st_r.fwft2 || !full_clear_fifo_two_n_q || hold2_done) begin
      st_nxt.ov2 = 1'b0;
    end else if (fifo_two_present) begin
      st_nxt.ov2 = 1'b1; // R13
    end else if (fifo_two_read) begin
      st_nxt.ov2 = 1'b0;
    end
    if (apb_write && paddr == BFC_ADDR_CONFIG) begin
      st_nxt.bsize = pwdata[1:0];
    end
    if (apb_setup) begin
      st_nxt.slverr = 1'b0;
      st_nxt.rdata = 32'h0000_0000;
      case (paddr)
        BFC_ADDR_CONFIG: st_nxt.rdata[1:0] = st_r.bsize;
        BFC_ADDR_STATUS: begin
          st_nxt.rdata[BFC_ST_BIG_POS] = st_r.big;
          st_nxt.rdata[BFC_ST_FWFT1_POS] = st_r.fwft1;
          st_nxt.rdata[BFC_ST_FWFT2_POS] = st_r.fwft2;
          st_nxt.rdata[BFC_ST_IP_POS] = st_r.ip;
          st_nxt.rdata[BFC_ST_DONE_POS] = st_r.prog == BFC_RUN;
          st_nxt.rdata[BFC_ST_SERIAL_POS] = st_r.prog == BFC_SERIAL;
        end
        BFC_ADDR_OFS_ONE: st_nxt.rdata = {{PADW{1'b0}}, st_r.y1, {PADW{1'b0}}, st_r.x1};
        BFC_ADDR_OFS_TWO: st_nxt.rdata = {{PADW{1'b0}}, st_r.y2, {PADW{1'b0}}, st_r.x2};
        default: st_nxt.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{prog: BFC_CLEAR, bsize: BFC_SIZE_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic room_a;
  logic room_b;
  assign pready = 1'b1;
  assign prdata = st_r.rdata;
  assign pslverr = st_r.slverr & psel & penable;
  assign port_b_lane = bfc_lane(st_r.bsize, port_b_beat, st_r.big); // R6 R8 R9
  assign fall_through_mode_one = st_r.fwft1;
  assign fall_through_mode_two = st_r.fwft2;
  assign fifo_one_store = tick_a && wr_q && st_r.prog == BFC_RUN &&
                          fifo_one_level != DEPTH; // R19

  // Port A keeps room during parallel loading since the offsets arrive there.
  assign room_a = full_clear_fifo_one_n_q && (st_r.prog == BFC_RUN || st_r.prog == BFC_PLOAD) &&
                  fifo_one_level != DEPTH;
  assign room_b = full_clear_fifo_two_n_q && st_r.prog == BFC_RUN && fifo_two_level != DEPTH; // R25
  assign port_a_full_n = !st_r.fwft1 && room_a; // R12
  assign port_a_input_room = st_r.fwft1 && room_a; // R13
  assign port_b_full_n = !st_r.fwft2 && room_b; // R12 R25
  assign port_b_input_room = st_r.fwft2 && room_b; // R13 R25
  assign port_b_empty_n = !st_r.fwft1 && full_clear_fifo_one_n_q && fifo_one_level != '0; // R12
  assign port_b_output_valid = st_r.fwft1 && st_r.ov1; // R13
  assign port_a_empty_n = !st_r.fwft2 && full_clear_fifo_two_n_q && fifo_two_level != '0; // R12
  assign port_a_output_valid = st_r.fwft2 && st_r.ov2; // R13
  assign port_b_almost_empty_n = full_clear_fifo_one_n_q && fifo_one_level > {1'b0, st_r.x1}; // R15
  assign port_a_almost_full_n = !full_clear_fifo_one_n_q || fifo_one_level < DEPTH - {1'b0, st_r.y1}; // R15
  assign port_a_almost_empty_n = full_clear_fifo_two_n_q && fifo_two_level > {1'b0, st_r.x2}; // R15
  assign port_b_almost_full_n = !full_clear_fifo_two_n_q || fifo_two_level < DEPTH - {1'b0, st_r.y2}; // R15

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb_pclk @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_full_clear_fifo_one_n_rise;
    full_clear_fifo_one_n_rise;
  endsequence
  sequence s_pload_write;
    st_r.prog == BFC_PLOAD && full_clear_fifo_one_n_q && tick_a && wr_q;
  endsequence

  a_rewind_mode: assert property ((fifo_one_rewind || fifo_two_rewind) |-> mode_q) // R4
    else $error("Rewind issued with mode select low.");
  a_partial_mode: assert property ((fifo_one_partial_clear || fifo_two_partial_clear)
    |-> !mode_q && !fifo_one_rewind && !fifo_two_rewind) // R4
    else $error("Partial clear issued with mode select high.");
  a_order_latch: assert property (s_full_clear_fifo_one_n_rise |=> st_r.big == $past(bo_q)) // R5 R7
    else $error("Byte order not latched at reset release.");
  a_timing_pick: assert property (st_r.wait1 && tick_a && full_clear_fifo_one_n_q && !full_clear_fifo_one_n_rise
    |=> st_r.fwft1 == !$past(bo_q) && !st_r.wait1) // R10 R11
    else $error("Timing mode not sampled on first Port A edge.");
  a_std_read: assert property (!st_r.fwft1 && fifo_one_present |-> fifo_one_read) // R12
    else $error("Standard mode presented a word without a read.");
  a_fall_through_mode_fall: assert property (st_r.fwft1 && full_clear_fifo_one_n_q && !st_r.ov1 && fifo_one_level != '0
    && !hold1_done |-> fifo_one_present ##1 port_b_output_valid) // R13
    else $error("First word did not fall through.");
  a_pload_skip: assert property (s_pload_write |-> !fifo_one_store) // R19
    else $error("Offset write was stored in memory.");
  a_pload_first: assert property (s_pload_write and st_r.idx == 2'h0
    |=> st_r.y1 == $past(pload_word) && st_r.idx == 2'h1) // R19 R20 R21
    else $error("First parallel write did not load the full offset.");
  a_room_b_held: assert property (st_r.prog != BFC_RUN
    |-> !port_b_full_n && !port_b_input_room) // R25
    else $error("Port B room raised before offsets were loaded.");
  a_lane_long: assert property (st_r.bsize == BFC_SIZE_LONG |-> port_b_lane == 2'h0) // R9
    else $error("Long word size used a byte order lane.");
  a_flag_clear: assert property (!full_clear_fifo_one_n_q |-> port_a_almost_full_n
    && !port_b_almost_empty_n) // R15
    else $error("Almost flags not forced during master clear.");
endmodule

//--- bfc_ctl_model.sv
// Controller model: free-running port clocks and Port A write pins.
// Assumes pclk is much faster than either port clock.
`timescale 1ns/1ps
module bfc_ctl_model (
  // Clock
  input wire logic pclk,
  // Port clocks and Port A write pins
  output logic port_a_clock,
  output logic port_b_clock,
  output logic port_a_write,
  output logic [35:0] port_a_data
);
  int ca = 0;
  int cb = 0;
  initial begin
    port_a_clock = 1'b0;
    port_b_clock = 1'b0;
    port_a_write = 1'b0;
    port_a_data = 36'h0;
  end
  // Periods of 10 and 14 pclk keep the two port clocks out of step.
  always @(posedge pclk) begin
    ca <= (ca == 4) ? 0 : ca + 1;
    cb <= (cb == 6) ? 0 : cb + 1;
    if (ca == 4) port_a_clock <= ~port_a_clock;
    if (cb == 6) port_b_clock <= ~port_b_clock;
  end
  // Data is inverted once released, so a late sample cannot pass.
  task automatic pa_write(input logic [35:0] d);
    @(negedge port_a_clock);
    port_a_data <= d;
    port_a_write <= 1'b1;
    @(negedge port_a_clock);
    port_a_write <= 1'b0;
    port_a_data <= ~d;
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the FIFO pair configuration unit.
// Assumes APB with zero wait states and the controller model for port pins.
`timescale 1ns/1ps
module tb_top;
  import bfc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, pa_clk, pb_clk, pa_wr, rw1 = 1, rw2 = 1, rms = 1;
  logic mc1 = 0, mc2 = 0, bo = 1, pb_full_n, rew1, rew2, pc1, pc2, st, aeb;
  logic [2:0] fs = 3'h7;
  logic [1:0] beat = 2'h0, lane;
  logic [35:0] pa_data;
  logic [11:0] lvl1 = 12'h000;
  logic [4:0] ev;
  logic [2:0] codes [5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
  int vals [5] = '{64, 16, 8, 256, 1024};
  int cnt [5] = '{default: 0};
  int err_count = 0, checks = 0, cyc = 0;
  assign ev = {st, pc2, pc1, rew2, rew1};
  initial forever #25 pclk = ~pclk;
  bfc_ctl_model i_ctl (.pclk(pclk), .port_a_clock(pa_clk), .port_b_clock(pb_clk),
    .port_a_write(pa_wr), .port_a_data(pa_data));
  bfc_config_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_a_clock(pa_clk), .port_b_clock(pb_clk),
    .rewind_fifo_one_n(rw1), .rewind_fifo_two_n(rw2), .rewind_mode_select(rms),
    .full_clear_fifo_one_n(mc1), .full_clear_fifo_two_n(mc2),
    .byte_order_timing_select(bo), .flag_select_0_serial_in(fs[0]),
    .flag_select_1_serial_load_n(fs[1]), .flag_select_2(fs[2]), .port_a_write(pa_wr),
    .port_a_data(pa_data), .fifo_one_level(lvl1), .fifo_two_level(12'h000),
    .fifo_one_read(1'b0), .fifo_two_read(1'b0), .port_b_beat(beat), .port_a_word(),
    .fifo_one_store(st), .fifo_one_rewind(rew1), .fifo_two_rewind(rew2),
    .fifo_one_partial_clear(pc1), .fifo_two_partial_clear(pc2), .fifo_one_present(),
    .fifo_two_present(), .port_b_lane(lane), .fall_through_mode_one(),
    .fall_through_mode_two(), .port_a_full_n(), .port_a_input_room(),
    .port_b_full_n(pb_full_n), .port_b_input_room(), .port_a_empty_n(),
    .port_a_output_valid(), .port_b_empty_n(), .port_b_output_valid(),
    .port_a_almost_empty_n(), .port_b_almost_empty_n(aeb), .port_a_almost_full_n(),
    .port_b_almost_full_n());
  always @(posedge pclk) begin
    for (int i = 0; i < 5; i++) if (ev[i] === 1'b1) cnt[i]++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Config pins settle with the clears low; bo stays static afterwards.
  task automatic mclear(input logic [2:0] f, input logic b);
    @(posedge pclk);
    mc1 <= 0;
    mc2 <= 0;
    fs <= f;
    bo <= b;
    repeat (60) @(posedge pclk);
    mc1 <= 1;
    mc2 <= 1;
    repeat (60) @(posedge pclk);
  endtask
  task automatic lanes(input logic [1:0] s, input logic [1:0] b, input logic [1:0] e);
    apb(1, BFC_ADDR_CONFIG, {30'h0, s});
    beat <= b;
    repeat (2) @(posedge pclk);
    chk({30'h0, lane}, {30'h0, e});
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    foreach (codes[i]) begin
      mclear(codes[i], i % 2 == 0);
      apb(0, BFC_ADDR_OFS_ONE, 0);
      chk(rd, vals[i] * 32'h10001);
      apb(0, BFC_ADDR_OFS_TWO, 0);
      chk(rd, vals[i] * 32'h10001);
      apb(0, BFC_ADDR_STATUS, 0);
      chk(rd & 32'h7, {29'h0, !bo, !bo, bo});
      lanes(BFC_SIZE_BYTE, 2'h1, bo ? 2'h2 : 2'h1);
      lanes(BFC_SIZE_WORD, 2'h0, bo ? 2'h1 : 2'h0);
      lanes(BFC_SIZE_LONG, 2'h0, 2'h0);
    end
    mclear(BFC_FS_SERIAL, 1);
    apb(0, BFC_ADDR_STATUS, 0);
    chk(rd & 32'h30, 32'h20);
    $display("preset, timing and byte order tests done");
    // Flag selects 0 and 1 stay low from here on; offsets stay in range.
    for (int ip = 0; ip < 2; ip++) begin
      mclear({ip == 0, 2'h0}, 1);
      cnt = '{default: 0};
      chk({31'h0, pb_full_n}, 0);
      for (int k = 0; k < 4; k++) begin
        if (ip == 0) i_ctl.pa_write({25'h1FFFFFF, 11'h5A0 + 11'(k)});
        else i_ctl.pa_write({24'hFFFFFF, 3'h5, 1'b1, 8'hA0 + 8'(k)});
      end
      repeat (60) @(posedge pclk);
      chk({31'h0, pb_full_n}, 1);
      chk(cnt[4], 0);
      apb(0, BFC_ADDR_OFS_ONE, 0);
      chk(rd, 32'h05A005A1);
      apb(0, BFC_ADDR_OFS_TWO, 0);
      chk(rd, 32'h05A205A3);
      apb(0, BFC_ADDR_STATUS, 0);
      chk(rd & 32'h18, {28'h1, ip == 1, 3'h0});
      lvl1 <= 12'h5A2;
      repeat (2) @(posedge pclk);
      chk({31'h0, aeb}, 1);
      lvl1 <= 12'h5A1;
      repeat (2) @(posedge pclk);
      chk({31'h0, aeb}, 0);
      lvl1 <= 12'h000;
    end
    $display("parallel load tests done");
    // Mode select is held for the whole hold and settles with the pin.
    for (int m = 0; m < 4; m++) begin
      cnt = '{default: 0};
      rms <= m >= 2;
      if (m % 2) rw2 <= 0;
      else rw1 <= 0;
      repeat (120) @(posedge pclk);
      rw1 <= 1;
      rw2 <= 1;
      repeat (20) @(posedge pclk);
      chk({cnt[0][7:0], cnt[1][7:0], cnt[2][7:0], cnt[3][7:0]},
          32'h1 << (8 * (1 + 2 * (m / 2) - m % 2)));
    end
    apb(0, BFC_ADDR_OFS_ONE, 0);
    chk(rd, 32'h05A005A1);
    $display("rewind and partial clear tests done");
    apb(0, 8'h40, 0);
    chk({31'h0, perr}, 1);
    chk(rd, 0);
    $display("unmapped access test done");
    summarize();
  end
endmodule
